// File: rtl/sps_top.sv
// Purpose: bipolar stepper translator with per-phase chopper and boost
// Assumes: step, direction, mode and sense inputs are asynchronous pins
// Notes: outputs registered; chopper shorts a winding via C or D
`include "sps_map.svh"

module sps_top
  import sps_pkg::*;
#(
  parameter int BOOST_NS = `SPS_BOOST_NS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Processor command lines
  input wire logic stepClk,
  input wire logic dirCw,
  input wire logic halfSel,
  // Options
  input wire logic boostEnable,
  input wire logic torqueCompEnable,
  // Current comparators
  input wire logic senseA,
  input wire logic senseB,
  // Bridge drive
  output logic phA,
  output logic phB,
  output logic phC,
  output logic phD,
  output logic inhA_n,
  output logic inhB_n,
  output logic highSupplyOn,
  output logic refBoost,
  // Status
  output logic [2:0] stepPos,
  output logic chopDecayA,
  output logic chopDecayB
);

  localparam int BOOST_CYC_I = (BOOST_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS;
  localparam logic [`SPS_BOOST_W-1:0] BOOST_CYC =
    (BOOST_CYC_I < 1) ? `SPS_BOOST_W'(1) : `SPS_BOOST_W'(BOOST_CYC_I);
  localparam logic [`SPS_CHOP_W-1:0] CHOP_LAST = `SPS_CHOP_W'(`SPS_CHOP_CYC - 1);
  localparam logic [`SPS_CHOP_W-1:0] BLANK_CYC = `SPS_CHOP_W'(`SPS_BLANK_CYC);

  // ----------------------------------------------------------------
  // Winding current code for a sequence index
  // ----------------------------------------------------------------
  function automatic sps_wind_t windCode(input sps_idx_t idx);
    sps_wind_t w;
    w.on = 1'b1;
    w.pos = 1'b0;
    if (idx == `SPS_IDX_A_OFF0 || idx == `SPS_IDX_A_OFF1)
      w.on = 1'b0;
    if (idx == `SPS_IDX_A_POS0 || idx == `SPS_IDX_A_POS1 || idx == `SPS_IDX_A_POS2)
      w.pos = 1'b1;
    return w;
  endfunction : windCode

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pinS1_q, pinS1_d;
  logic [2:0] pinS2_q, pinS2_d;
  logic stepPrev_q, stepPrev_d;
  logic stepEdge;
  logic dirS, halfS;

  always_comb
  begin
    // Only stage two feeds logic; stage one may still be settling
    pinS1_d = {halfSel, dirCw, stepClk}; // RQ18
    pinS2_d = pinS1_q;
    stepPrev_d = pinS2_q[0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinS1_q <= 3'h0;
      pinS2_q <= 3'h0;
      stepPrev_q <= 1'b0;
    end
    else
    begin
      pinS1_q <= pinS1_d;
      pinS2_q <= pinS2_d;
      stepPrev_q <= stepPrev_d;
    end
  end

  assign stepEdge = pinS2_q[0] && !stepPrev_q;
  assign dirS = pinS2_q[1];
  assign halfS = pinS2_q[2];

  // ----------------------------------------------------------------
  // Translator
  // ----------------------------------------------------------------
  sps_idx_t idx_q, idx_d;
  sps_idx_t inc;
  logic half_q, half_d;

  always_comb
  begin
    // Full step from an odd index realigns by one first
    inc = `SPS_HALF_INC;
    if (!halfS && !idx_q[0])
      inc = `SPS_FULL_INC; // RQ1
    half_d = halfS;
    idx_d = idx_q;
    if (stepEdge)
    begin
      if (dirS)
        idx_d = idx_q + inc; // RQ2 RQ3 RQ24
      else
        idx_d = idx_q - inc; // RQ2 RQ3 RQ24
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx_q <= `SPS_IDX_RESET; // RQ20
      half_q <= 1'b0;
    end
    else
    begin
      idx_q <= idx_d;
      half_q <= half_d;
    end
  end

  // ----------------------------------------------------------------
  // Shared chopping oscillator
  // ----------------------------------------------------------------
  logic [`SPS_CHOP_W-1:0] chopCnt_q, chopCnt_d;

  always_comb
  begin
    chopCnt_d = chopCnt_q + `SPS_CHOP_W'(1);
    if (chopCnt_q == CHOP_LAST)
      chopCnt_d = '0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      chopCnt_q <= '0;
    else
      chopCnt_q <= chopCnt_d;
  end

  // ----------------------------------------------------------------
  // Per-phase regulators
  // ----------------------------------------------------------------
  sps_chop_if chopBus[`SPS_NUM_PHASES] ();
  logic [`SPS_NUM_PHASES-1:0] senseVec;
  logic [`SPS_NUM_PHASES-1:0] decayVec;

  assign senseVec = {senseB, senseA};

  genvar g;
  generate
    for (g = 0; g < `SPS_NUM_PHASES; g++)
    begin : gPhase
      // Blanking hides recovery spikes right after reconnect
      assign chopBus[g].oscStart = (chopCnt_q == '0); // RQ22
      assign chopBus[g].blanking = (chopCnt_q < BLANK_CYC);
      assign chopBus[g].senseRaw = senseVec[g];
      assign decayVec[g] = chopBus[g].decay;
      sps_chopper uChop
      (
        .clk(clk),
        .rst_n(rst_n),
        .chop(chopBus[g].reg_side)
      ); // RQ12
    end
  endgenerate

  // ----------------------------------------------------------------
  // Boost timer
  // ----------------------------------------------------------------
  logic [`SPS_BOOST_W-1:0] boostCnt_q, boostCnt_d;

  always_comb
  begin
    boostCnt_d = boostCnt_q;
    // Retriggered by every step; the high supply never stays on while idle
    if (stepEdge && boostEnable)
      boostCnt_d = BOOST_CYC; // RQ13
    else if (boostCnt_q != '0)
      boostCnt_d = boostCnt_q - `SPS_BOOST_W'(1); // RQ14
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      boostCnt_q <= '0;
    else
      boostCnt_q <= boostCnt_d;
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Registered drive, so the bridges never see decode glitches
  sps_wind_t codeA, codeB;
  logic [3:0] ph_q, ph_d;
  logic [1:0] inh_q, inh_d;
  logic refBoost_q, refBoost_d;
  logic highSupply_q, highSupply_d;
  logic [1:0] decay_q, decay_d;

  always_comb
  begin
    codeA = windCode(idx_d);
    codeB = windCode(idx_d - `SPS_B_OFFSET);
    ph_d[0] = codeA.on && codeA.pos; // RQ4
    ph_d[1] = codeB.on && codeB.pos; // RQ4
    ph_d[2] = codeA.on && !codeA.pos;
    ph_d[3] = codeB.on && !codeB.pos;
    // Equiphase on both legs shorts the winding during decay
    if (decayVec[0])
      ph_d[2] = ph_d[0]; // RQ9
    if (decayVec[1])
      ph_d[3] = ph_d[1]; // RQ9
    inh_d[0] = half_d ? codeA.on : 1'b1; // RQ5 RQ21
    inh_d[1] = half_d ? codeB.on : 1'b1; // RQ5 RQ21
    refBoost_d = torqueCompEnable && half_d && !(inh_d[0] && inh_d[1]); // RQ15
    highSupply_d = (boostCnt_d != '0);
    decay_d = decayVec;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_q <= `SPS_PH_RESET; // RQ20
      inh_q <= `SPS_INH_RESET; // RQ21
      refBoost_q <= 1'b0;
      highSupply_q <= 1'b0;
      decay_q <= 2'h0;
    end
    else
    begin
      ph_q <= ph_d;
      inh_q <= inh_d;
      refBoost_q <= refBoost_d;
      highSupply_q <= highSupply_d;
      decay_q <= decay_d;
    end
  end

  assign phA = ph_q[0];
  assign phB = ph_q[1];
  assign phC = ph_q[2];
  assign phD = ph_q[3];
  assign inhA_n = inh_q[0];
  assign inhB_n = inh_q[1];
  assign refBoost = refBoost_q;
  assign highSupplyOn = highSupply_q;
  assign stepPos = idx_q; // RQ7
  assign chopDecayA = decay_q[0];
  assign chopDecayB = decay_q[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  fullInhHigh_a: assert property (!half_q |-> inhA_n && inhB_n) // RQ21
    else $error("inhibit low in full step");
  halfFwd_a: assert property (stepEdge && halfS && dirS |=> stepPos == $past(stepPos) + 3'h1) // RQ3
    else $error("half step forward wrong");
  halfRev_a: assert property (stepEdge && halfS && !dirS |=> stepPos == $past(stepPos) - 3'h1) // RQ2
    else $error("half step reverse wrong");
  noStep_a: assert property (!stepEdge |=> $stable(stepPos)) // RQ3
    else $error("position moved without step");
  fullEven_a: assert property (stepEdge && !halfS |=> !stepPos[0]) // RQ1
    else $error("full step left odd position");
  quadStep_a: assert property (stepEdge && !halfS && !stepPos[0] |=> $changed(phA) != $changed(phB)) // RQ1
    else $error("full step broke quadrature");
  boostOn_a: assert property (stepEdge && boostEnable |=> highSupplyOn [*8]) // RQ13
    else $error("boost not applied");
  boostOff_a: assert property (!boostEnable && boostCnt_q == '0 |=> !highSupplyOn) // RQ14
    else $error("boost stayed on");
  compOff_a: assert property (!half_q |-> !refBoost) // RQ15
    else $error("setpoint raised in full step");
  chopShort_a: assert property ($past(decayVec[0]) && inhA_n |-> phA == phC) // RQ9
    else $error("winding A not shorted in decay");
  // Registered outputs lag the decode by one cycle
  inhFloatA_a: assert property (half_q && !inhA_n |-> !phA && !phC) // RQ5
    else $error("floating bridge A still driven");
  inhFloatB_a: assert property (half_q && !inhB_n |-> !phB && !phD) // RQ5
    else $error("floating bridge B still driven");
  raiseSet_a: assert property ($past(torqueCompEnable) && half_q && !inhA_n |-> refBoost) // RQ15
    else $error("setpoint not raised with one phase");
  fullOdd_a: assert property (stepEdge && !halfS && dirS && stepPos[0] |=> // RQ1
    stepPos == $past(stepPos) + 3'h1)
    else $error("full step from odd index wrong");

endmodule : sps_top

// File: rtl/sps_map.svh
// Purpose: constants for the stepper phase sequencer and chopper
// Assumes: 50 MHz system clock
// Notes: rule summary below, tags used in the design files
//
// Functional notes
// RQ1: Full-step drives two square phase signals held ninety degrees apart.
// RQ2: Direction input picks which phase leads, reversing the rotation.
// RQ3: Each step clock pulse advances the pattern exactly one position.
// RQ4: Half-step mode produces four phase control signals.
// RQ5: Half-step adds two inhibit outputs that float an unpowered bridge.
// RQ6: Processor issues twice the step pulses in half-step for equal travel.
// RQ7: Half-step doubles position resolution, eight positions per electrical cycle.
// RQ8: Winding stays on supply until the sense comparator trips.
// RQ9: On current limit the winding is shorted so current decays slowly.
// RQ10: Decay interval is timed by the oscillator, not by the sense.
// RQ11: When decay ends the winding reconnects and a new cycle starts.
// RQ12: Each phase has its own independent chopping regulator.
// RQ13: Boost option connects both windings to high supply at each step.
// RQ14: After the boost time the high supply switch opens again.
// RQ15: Raise setpoint by root two while only one phase is powered.
// RQ16: Processor avoids stopping in half-step with boosted current applied.
// RQ17: Processor may use half-step only inside the resonance range.
// RQ18: All phase and inhibit signals made here from three control lines.
// RQ19: Processor supplies step clock, reset, direction and half/full select.
// RQ20: Reset forces the phase outputs to a defined start position.
// RQ21: In full-step both inhibit outputs stay high.
// RQ22: Shared oscillator resets both current flops, set beats reset.
// RQ23: Comparator inputs pass a two-stage synchroniser before use.
// RQ24: Half-step walks eight states, alternating one and two phases on.
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SPS_CLK_NS 20
`define SPS_CHOP_PERIOD_NS 50000
`define SPS_BLANK_NS 1000
`define SPS_BOOST_NS 200000
`define SPS_CHOP_CYC (`SPS_CHOP_PERIOD_NS / `SPS_CLK_NS)
`define SPS_BLANK_CYC ((`SPS_BLANK_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)
`define SPS_CHOP_W 12
`define SPS_BOOST_W 16

// ----------------------------------------------------------------
// Sequence
// ----------------------------------------------------------------
`define SPS_IDX_RESET 3'h0
`define SPS_PH_RESET 4'h3
`define SPS_INH_RESET 2'h3
`define SPS_HALF_INC 3'h1
`define SPS_FULL_INC 3'h2
`define SPS_B_OFFSET 3'h2
`define SPS_IDX_A_OFF0 3'h1
`define SPS_IDX_A_OFF1 3'h5
`define SPS_IDX_A_POS0 3'h0
`define SPS_IDX_A_POS1 3'h6
`define SPS_IDX_A_POS2 3'h7
`define SPS_NUM_PHASES 2

`endif

// File: rtl/sps_pkg.sv
// Purpose: shared types for the stepper sequencer
// Assumes: nothing
// Notes: none
package sps_pkg;

  typedef logic [2:0] sps_idx_t;

  typedef struct packed {
    logic on;
    logic pos;
  } sps_wind_t;

  typedef enum logic {SPS_DRIVE, SPS_DECAY} sps_chop_t;

endpackage : sps_pkg

// File: rtl/sps_chop_if.sv
// Purpose: link between the sequencer and one chopping regulator
// Assumes: single clock domain
// Notes: oscStart is a one-cycle pulse, blanking a level
interface sps_chop_if;
  logic oscStart;
  logic blanking;
  logic senseRaw;
  logic decay;

  modport seq (output oscStart, output blanking, output senseRaw, input decay);
  modport reg_side (input oscStart, input blanking, input senseRaw, output decay);
endinterface : sps_chop_if

// File: rtl/sps_chopper.sv
// Purpose: one phase current regulator, set-dominant chop latch
// Assumes: comparator output is asynchronous to clk
// Notes: decay lasts until the next oscillator period start
`include "sps_map.svh"

module sps_chopper
  import sps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sequencer link
  sps_chop_if.reg_side chop
);

  logic senseS1_q, senseS1_d;
  logic senseS2_q, senseS2_d;
  sps_chop_t state_q, state_d;
  logic tripSet;

  assign tripSet = senseS2_q && !chop.blanking;

  always_comb
  begin
    senseS1_d = chop.senseRaw; // RQ23
    senseS2_d = senseS1_q; // RQ23
    state_d = state_q;
    unique case (state_q)
      SPS_DRIVE:
      begin
        if (tripSet)
          state_d = SPS_DECAY; // RQ8
      end
      SPS_DECAY:
      begin
        // Set wins, so a trip inside the start pulse keeps decay
        if (chop.oscStart && !tripSet)
          state_d = SPS_DRIVE; // RQ10 RQ11 RQ22
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      senseS1_q <= 1'b0;
      senseS2_q <= 1'b0;
      state_q <= SPS_DRIVE;
    end
    else
    begin
      senseS1_q <= senseS1_d;
      senseS2_q <= senseS2_d;
      state_q <= state_d;
    end
  end

  assign chop.decay = (state_q == SPS_DECAY); // RQ9

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  tripEnters_a: assert property (tripSet |=> chop.decay) // RQ22
    else $error("trip did not enter decay");
  decayHolds_a: assert property (chop.decay && !chop.oscStart |=> chop.decay) // RQ10
    else $error("decay ended without oscillator");
  restartDrive_a: assert property (chop.oscStart && !tripSet |=> !chop.decay) // RQ11
    else $error("oscillator did not restart drive");
  blankNoSet_a: assert property (!chop.decay && chop.blanking |=> !chop.decay) // RQ22
    else $error("set during blanking");

endmodule : sps_chopper

// File: test/sps_cmd_model.sv
// Purpose: command-side model issuing step pulses and mode levels
// Assumes: levels must settle three cycles before a step edge
// Notes: pulse is kept at the shortest legal width, high 2 and low 6 cycles between back-to-back steps
module sps_cmd_model
(
  // Clock
  input wire logic clk,
  // Command lines
  output logic stepClk,
  output logic dirCw,
  output logic halfSel
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    stepClk = 1'b0;
    dirCw = 1'b1;
    halfSel = 1'b0;
  end

  // ----------------------------------------------------------------
  // One step command
  // ----------------------------------------------------------------
  // Half-step callers simply issue twice the pulses for equal travel
  task automatic step(input logic dir, input logic half);
    dirCw <= dir;
    halfSel <= half;
    repeat (3) @(posedge clk);
    stepClk <= 1'b1;
    repeat (2) @(posedge clk);
    stepClk <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : step

endmodule : sps_cmd_model

// File: test/sps_top_tb.sv
// Purpose: self-checking bench for the stepper sequencer and chopper
// Assumes: short boost parameter, sense pins driven by the bench
// Notes: expected drive patterns come from the bench's own tables
module sps_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int BoostNs = 400;
  localparam int BoostCyc = BoostNs / 20;

  logic clk;
  logic rst_n;
  logic stepClk;
  logic dirCw;
  logic halfSel;
  logic boostEnable;
  logic torqueCompEnable;
  logic senseA;
  logic senseB;
  logic phA;
  logic phB;
  logic phC;
  logic phD;
  logic inhA_n;
  logic inhB_n;
  logic highSupplyOn;
  logic refBoost;
  logic [2:0] stepPos;
  logic chopDecayA;
  logic chopDecayB;
  int failCount = 0;
  int checks = 0;
  int seed = 82;

  sps_top #(.BOOST_NS(BoostNs)) u_dut (.clk(clk), .rst_n(rst_n), .stepClk(stepClk),
    .dirCw(dirCw), .halfSel(halfSel), .boostEnable(boostEnable),
    .torqueCompEnable(torqueCompEnable), .senseA(senseA), .senseB(senseB), .phA(phA),
    .phB(phB), .phC(phC), .phD(phD), .inhA_n(inhA_n), .inhB_n(inhB_n),
    .highSupplyOn(highSupplyOn), .refBoost(refBoost), .stepPos(stepPos),
    .chopDecayA(chopDecayA), .chopDecayB(chopDecayB));

  sps_cmd_model u_cmd (.clk(clk), .stepClk(stepClk), .dirCw(dirCw), .halfSel(halfSel));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Expectation helpers
  // ----------------------------------------------------------------
  // Winding polarity as {high leg, low leg}; both low means unpowered
  function automatic logic [1:0] pol_a(input logic [2:0] i);
    case (i)
      3'h0, 3'h6, 3'h7: pol_a = 2'h2;
      3'h1, 3'h5: pol_a = 2'h0;
      default: pol_a = 2'h1;
    endcase
  endfunction : pol_a

  function automatic logic [5:0] exp_drive(input logic [2:0] i, input logic half);
    logic [1:0] a;
    logic [1:0] b;
    a = pol_a(i);
    b = pol_a(i - 3'h2);
    exp_drive = {a[1], b[1], a[0], b[0], ~half | (a != 2'h0), ~half | (b != 2'h0)};
  endfunction : exp_drive

  // Full step from an odd position first lands on the even neighbour
  function automatic logic [2:0] next_idx(input logic [2:0] i, input logic dir,
    input logic half);
    logic [2:0] inc;
    inc = (half || i[0]) ? 3'h1 : 3'h2;
    next_idx = dir ? i + inc : i - inc;
  endfunction : next_idx

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = highSupplyOn;
      1: pick = chopDecayA;
      default: pick = chopDecayB;
    endcase
  endfunction : pick

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    checks++;
    if (seen !== want)
    begin
      failCount++;
      $display("BAD %0t %s seen %0h want %0h", $time, what, seen, want);
    end
  endtask : check

  // Bounded wait; a wait that runs out ends the run
  task automatic wait_sig(input int sel, input logic lvl, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pick(sel) !== lvl && n < lim);
    if (pick(sel) !== lvl)
    begin
      failCount++;
      $display("BAD %0t wait ran out on signal %0d", $time, sel);
      close_out();
    end
  endtask : wait_sig

  task automatic check_drive(input logic [2:0] i, input logic half);
    check({phA, phB, phC, phD, inhA_n, inhB_n}, exp_drive(i, half), "drive");
    check(stepPos, i, "position");
    check(refBoost, half & i[0] & torqueCompEnable, "setpoint raise");
  endtask : check_drive

  task automatic reset_pulse();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    check_drive(3'h0, 1'b0);
    check({highSupplyOn, chopDecayA, chopDecayB}, 3'h0, "reset idle");
    rst_n <= 1'b1;
    @(posedge clk);
  endtask : reset_pulse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [2:0] idx;
    logic d;
    logic h;
    int n;
    rst_n = 1'b0;
    boostEnable = 1'b0;
    torqueCompEnable = 1'b0;
    senseA = 1'b0;
    senseB = 1'b0;
    @(posedge clk);
    reset_pulse();
    idx = 3'h0;
    // Eight half steps make one electrical turn back to the start
    for (int k = 0; k < 8; k++)
    begin
      u_cmd.step(1'b1, 1'b1);
      idx = next_idx(idx, 1'b1, 1'b1);
      check_drive(idx, 1'b1);
    end
    check(stepPos, 3'h0, "full turn");
    for (int k = 0; k < 48; k++)
    begin
      d = 1'($random(seed));
      h = 1'($random(seed));
      torqueCompEnable <= 1'($random(seed));
      u_cmd.step(d, h);
      idx = next_idx(idx, d, h);
      check_drive(idx, h);
    end
    boostEnable <= 1'b1;
    fork
      u_cmd.step(1'b1, 1'b0);
      begin
        wait_sig(0, 1'b1, 20, n);
        check(stepPos, next_idx(idx, 1'b1, 1'b0), "boost start");
        n = 0;
        while (highSupplyOn === 1'b1 && n < 100)
        begin
          @(posedge clk);
          n++;
        end
      end
    join
    check(16'(n), 16'(BoostCyc), "boost length");
    boostEnable <= 1'b0;
    senseA <= 1'b1;
    wait_sig(1, 1'b1, 2600, n);
    check(chopDecayB, 1'b0, "other phase idle");
    @(posedge clk);
    check({phC, phA}, {phA, phA}, "winding shorted");
    // Sense held high: only the oscillator may end the decay
    wait_sig(1, 1'b0, 2600, n);
    wait_sig(1, 1'b1, 100, n);
    check((n >= 50 && n <= 56), 1'b1, "blanked retrip");
    senseA <= 1'b0;
    wait_sig(1, 1'b0, 2600, n);
    senseB <= 1'b1;
    wait_sig(2, 1'b1, 2600, n);
    check(chopDecayA, 1'b0, "phase A idle");
    @(posedge clk);
    check({phD, phB}, {phB, phB}, "winding B shorted");
    senseB <= 1'b0;
    wait_sig(2, 1'b0, 2600, n);
    reset_pulse();
    close_out();
  end

endmodule : sps_top_tb
